// *** logic/irq_ctrl_map.svh ***
// Register offsets, field positions, reset values and vector constants
// for the eight-source interrupt controller. Definitions only.
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// ==========================================================
// Special function register offsets
`define OFF_EXT_IRQ_CONTROL 8'hC0
`define OFF_TIMER_CONTROL 8'h88
`define OFF_IRQ_ENABLE 8'hA8
`define OFF_IRQ_PRIO 8'hB8
`define OFF_POWER_CONTROL 8'h87

// ==========================================================
// Extra external interrupt control fields
`define BIT_IRQ3_HIGH_PRIO 7
`define BIT_IRQ3_ENABLE 6
`define BIT_IRQ3_PENDING 5
`define BIT_IRQ3_EDGE_SELECT 4
`define BIT_IRQ2_HIGH_PRIO 3
`define BIT_IRQ2_ENABLE 2
`define BIT_IRQ2_PENDING 1
`define BIT_IRQ2_EDGE_SELECT 0

// ==========================================================
// Timer control and power control fields
`define BIT_TC_EDGE0 0
`define BIT_TC_PEND0 1
`define BIT_TC_EDGE1 2
`define BIT_TC_PEND1 3
`define BIT_TC_T0_FLAG 5
`define BIT_TC_T1_FLAG 7
`define BIT_SLEEP_CORE 0
`define BIT_DEEP_STOP 1

// ==========================================================
// Reset values and vectors
`define RST_SFR 8'h00
`define VEC_BASE 8'h03
`define VEC_STEP 8'h08

`endif

// *** logic/irq_ctrl_pkg.sv ***
// Types shared by the interrupt controller files.
// Assumes the map header supplies all numeric constants.
package irq_ctrl_pkg;

  typedef enum logic {ARB, OFFER} arb_state_t;
  typedef logic [2:0] src_idx_t;

endpackage

// *** logic/ext_irq_detect.sv ***
// Synchroniser and falling-edge / low-level detector for one external
// interrupt pin. Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module ext_irq_detect
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic fall_seen,
  output logic low_seen
);

  logic sync1_r, sync2_r, prev_r, fall_r;
  logic fall_nxt;

  always_comb
  begin
    fall_nxt = prev_r & ~sync2_r;
  end

  // Pins idle high, so reset to one avoids a false edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
      fall_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_n;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      fall_r <= fall_nxt;
    end
  end

  assign fall_seen = fall_r;
  assign low_seen = ~prev_r;

endmodule // ext_irq_detect

`default_nettype wire

// *** logic/eight_source_interrupt_ctrl.sv ***
// Eight-source, two-level interrupt controller with its control registers.
// Assumes a core-side register port with byte and single-bit writes, and a
// core that acknowledges a vector and signals return from service.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_map.svh"

module eight_source_interrupt_ctrl
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_val,
  input wire logic ext_irq0_n,
  input wire logic ext_irq1_n,
  input wire logic ext_irq2_n,
  input wire logic ext_irq3_n,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_irq,
  input wire logic serial_irq,
  output logic irq_req,
  output logic [7:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic core_clk_en,
  output logic osc_en
);

  // ==========================================================
  // Reset release
  logic rst_s1_r, rst_n;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ==========================================================
  // Pin detectors
  logic [3:0] fall, low;

  // two extra pins use the same detector as 0/1
  ext_irq_detect u_det0 (.clk(clk), .rst_n(rst_n), .pin_n(ext_irq0_n),
    .fall_seen(fall[0]), .low_seen(low[0]));
  ext_irq_detect u_det1 (.clk(clk), .rst_n(rst_n), .pin_n(ext_irq1_n),
    .fall_seen(fall[1]), .low_seen(low[1]));
  ext_irq_detect u_det2 (.clk(clk), .rst_n(rst_n), .pin_n(ext_irq2_n),
    .fall_seen(fall[2]), .low_seen(low[2]));
  ext_irq_detect u_det3 (.clk(clk), .rst_n(rst_n), .pin_n(ext_irq3_n),
    .fall_seen(fall[3]), .low_seen(low[3]));

  // ==========================================================
  // Helpers
  // byte write, or bit write touching one bit only
  function automatic logic [7:0] sw_upd(input logic [7:0] old, input logic [7:0] off,
                                        input logic bit_ok);
    logic [7:0] v;
    v = old;
    if (sfr_wr && sfr_addr == off)
      v = sfr_wdata;
    else if (bit_ok && bit_wr && bit_addr[7:3] == off[7:3])
      v[bit_addr[2:0]] = bit_val;
    return v;
  endfunction

  function automatic src_idx_t first_idx(input logic [7:0] v);
    src_idx_t r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] ctl_r, ctl_nxt, timer_control_reg_r, timer_control_reg_nxt, ie_r, ie_nxt;
  logic [7:0] ip_r, ip_nxt, power_control_reg_r, power_control_reg_nxt;
  logic [7:0] flag_vec, en_vec, prio_vec, req, req_hi, req_lo, clr_vec;
  arb_state_t st_r, st_nxt;
  src_idx_t off_idx_r, off_idx_nxt;
  logic off_hi_r, off_hi_nxt, in_hi_r, in_hi_nxt, in_lo_r, in_lo_nxt;
  logic [7:0] rdata_r, rdata_nxt, vec_r, vec_nxt;
  logic grant_hi, grant_lo, take;

  // control fields picked by bit position
  // enables; one priority bit per source
  always_comb
  begin
    flag_vec = {ctl_r[`BIT_IRQ3_PENDING], ctl_r[`BIT_IRQ2_PENDING], timer2_irq,
                serial_irq, timer_control_reg_r[`BIT_TC_T1_FLAG], timer_control_reg_r[`BIT_TC_PEND1],
                timer_control_reg_r[`BIT_TC_T0_FLAG], timer_control_reg_r[`BIT_TC_PEND0]};
    en_vec = {ctl_r[`BIT_IRQ3_ENABLE], ctl_r[`BIT_IRQ2_ENABLE], ie_r[5:0]};
    prio_vec = {ctl_r[`BIT_IRQ3_HIGH_PRIO], ctl_r[`BIT_IRQ2_HIGH_PRIO], ip_r[5:0]};
    req = flag_vec & en_vec;
    req_hi = req & prio_vec;
    req_lo = req & ~prio_vec;
    take = (st_r == OFFER) && irq_ack;
    clr_vec = take ? (8'h01 << off_idx_r) : 8'h00;
  end

  // ==========================================================
  // Register next values; hardware set wins over any clear
  always_comb
  begin
    // control register at its own offset
    ctl_nxt = sw_upd(ctl_r, `OFF_EXT_IRQ_CONTROL, 1'b1);
    timer_control_reg_nxt = sw_upd(timer_control_reg_r, `OFF_TIMER_CONTROL, 1'b1);
    ie_nxt = sw_upd(ie_r, `OFF_IRQ_ENABLE, 1'b1);
    ip_nxt = sw_upd(ip_r, `OFF_IRQ_PRIO, 1'b1);
    power_control_reg_nxt = sw_upd(power_control_reg_r, `OFF_POWER_CONTROL, 1'b0);
    // cleared on vectoring: pin flags in edge mode, timer flags always
    if (clr_vec[0] && timer_control_reg_r[`BIT_TC_EDGE0])
      timer_control_reg_nxt[`BIT_TC_PEND0] = 1'b0;
    if (clr_vec[2] && timer_control_reg_r[`BIT_TC_EDGE1])
      timer_control_reg_nxt[`BIT_TC_PEND1] = 1'b0;
    if (clr_vec[1])
      timer_control_reg_nxt[`BIT_TC_T0_FLAG] = 1'b0;
    if (clr_vec[3])
      timer_control_reg_nxt[`BIT_TC_T1_FLAG] = 1'b0;
    if (clr_vec[6] && ctl_r[`BIT_IRQ2_EDGE_SELECT])
      ctl_nxt[`BIT_IRQ2_PENDING] = 1'b0;
    if (clr_vec[7] && ctl_r[`BIT_IRQ3_EDGE_SELECT])
      ctl_nxt[`BIT_IRQ3_PENDING] = 1'b0;
    if (timer0_ovf)
      timer_control_reg_nxt[`BIT_TC_T0_FLAG] = 1'b1;
    if (timer1_ovf)
      timer_control_reg_nxt[`BIT_TC_T1_FLAG] = 1'b1;
    // trigger bits TC 0/2, control bits 0/4
    // edge sets on fall, else flag tracks low level
    // level mode pending follows the pin
    timer_control_reg_nxt[`BIT_TC_PEND0] = timer_control_reg_r[`BIT_TC_EDGE0] ?
      (timer_control_reg_nxt[`BIT_TC_PEND0] | fall[0]) : low[0];
    timer_control_reg_nxt[`BIT_TC_PEND1] = timer_control_reg_r[`BIT_TC_EDGE1] ?
      (timer_control_reg_nxt[`BIT_TC_PEND1] | fall[1]) : low[1];
    ctl_nxt[`BIT_IRQ2_PENDING] = ctl_r[`BIT_IRQ2_EDGE_SELECT] ?
      (ctl_nxt[`BIT_IRQ2_PENDING] | fall[2]) : low[2];
    ctl_nxt[`BIT_IRQ3_PENDING] = ctl_r[`BIT_IRQ3_EDGE_SELECT] ?
      (ctl_nxt[`BIT_IRQ3_PENDING] | fall[3]) : low[3];
    if (power_control_reg_r[`BIT_DEEP_STOP])
      power_control_reg_nxt[`BIT_DEEP_STOP] = 1'b1;
    if (|req)
      power_control_reg_nxt[`BIT_SLEEP_CORE] = 1'b0;
    rdata_nxt = rdata_r;
    if (sfr_rd)
    begin
      if (sfr_addr == `OFF_EXT_IRQ_CONTROL)
        rdata_nxt = ctl_r;
      else if (sfr_addr == `OFF_TIMER_CONTROL)
        rdata_nxt = timer_control_reg_r;
      else if (sfr_addr == `OFF_IRQ_ENABLE)
        rdata_nxt = ie_r;
      else if (sfr_addr == `OFF_IRQ_PRIO)
        rdata_nxt = ip_r;
      else if (sfr_addr == `OFF_POWER_CONTROL)
        rdata_nxt = power_control_reg_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  // ==========================================================
  // Arbitration and service tracking
  always_comb
  begin
    // high waits only for high; low waits for both
    grant_hi = (|req_hi) && !in_hi_r;
    grant_lo = (|req_lo) && !in_hi_r && !in_lo_r;
    st_nxt = st_r;
    off_idx_nxt = off_idx_r;
    off_hi_nxt = off_hi_r;
    vec_nxt = vec_r;
    in_hi_nxt = in_hi_r;
    in_lo_nxt = in_lo_r;
    if (irq_return)
    begin
      if (in_hi_r)
        in_hi_nxt = 1'b0;
      else
        in_lo_nxt = 1'b0;
    end
    case (st_r)
      ARB:
      begin
        if (grant_hi || grant_lo)
        begin
          // poll order inside the chosen level
          off_idx_nxt = grant_hi ? first_idx(req_hi) : first_idx(req_lo);
          off_hi_nxt = grant_hi;
          // vector = base + index * step
          // same formula covers the last four
          vec_nxt = `VEC_BASE + {off_idx_nxt, 3'b000};
          st_nxt = OFFER;
        end
      end
      OFFER:
      begin
        if (irq_ack)
        begin
          if (off_hi_r)
            in_hi_nxt = 1'b1;
          else
            in_lo_nxt = 1'b1;
          st_nxt = ARB;
        end
        else if (!req[off_idx_r] || (!off_hi_r && grant_hi))
          // Withdraw a vanished request or let high level overtake
          st_nxt = ARB;
      end
      default:
        st_nxt = ARB;
    endcase
  end

  // reset clears every register to zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= `RST_SFR;
      timer_control_reg_r <= `RST_SFR;
      ie_r <= `RST_SFR;
      ip_r <= `RST_SFR;
      power_control_reg_r <= `RST_SFR;
      rdata_r <= `RST_SFR;
      vec_r <= `RST_SFR;
      st_r <= ARB;
      off_idx_r <= 3'h0;
      off_hi_r <= 1'b0;
      in_hi_r <= 1'b0;
      in_lo_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      timer_control_reg_r <= timer_control_reg_nxt;
      ie_r <= ie_nxt;
      ip_r <= ip_nxt;
      power_control_reg_r <= power_control_reg_nxt;
      rdata_r <= rdata_nxt;
      vec_r <= vec_nxt;
      st_r <= st_nxt;
      off_idx_r <= off_idx_nxt;
      off_hi_r <= off_hi_nxt;
      in_hi_r <= in_hi_nxt;
      in_lo_r <= in_lo_nxt;
    end
  end

  // no gating here, so detection runs through idle
  assign core_clk_en = ~power_control_reg_r[`BIT_SLEEP_CORE] & ~power_control_reg_r[`BIT_DEEP_STOP];
  assign osc_en = ~power_control_reg_r[`BIT_DEEP_STOP];
  assign irq_req = (st_r == OFFER);
  assign irq_vector = vec_r;
  assign sfr_rdata = rdata_r;

  // ==========================================================
  // Checks
  a_vector_map: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> irq_vector == 8'(8'h03 + {off_idx_r, 3'b000}))
    else $error("vector does not match source index");

  a_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req && !en_vec[off_idx_r] |=> !irq_req)
    else $error("disabled source kept its offer");

  a_edge_clear: assert property (@(posedge clk) disable iff (!rst_n)
    take && off_idx_r == 3'h6 && ctl_r[0] && !fall[2] && !(bit_wr || sfr_wr)
    |=> !ctl_r[1])
    else $error("edge pending not cleared on vectoring");

  a_edge_set: assert property (@(posedge clk) disable iff (!rst_n)
    fall[2] && ctl_r[0] |=> ctl_r[1])
    else $error("falling edge lost");

  a_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl_r[4] |=> ctl_r[5] == $past(low[3]))
    else $error("level pending does not follow pin");

  a_high_first: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_req) |-> off_hi_r == ($past(req_hi) != 8'h00 && !$past(in_hi_r)))
    else $error("priority level chosen wrongly");

  a_poll_order: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_req) |-> (((off_hi_r ? $past(req_hi) : $past(req_lo)) &
      ((8'h01 << off_idx_r) - 8'h01)) == 8'h00))
    else $error("lower poll index was skipped");

  a_no_nesting: assert property (@(posedge clk) disable iff (!rst_n)
    in_hi_r |-> !(irq_req && !off_hi_r))
    else $error("low offer during high service");

  a_deep_stop: assert property (@(posedge clk) disable iff (!rst_n)
    power_control_reg_r[1] |=> power_control_reg_r[1] && !osc_en)
    else $error("power-down left without reset");

  a_idle_wake: assert property (@(posedge clk) disable iff (!rst_n)
    power_control_reg_r[0] && (|req) |=> !power_control_reg_r[0])
    else $error("enabled request did not end idle");

  a_reset_vals: assert property (@(posedge clk)
    $rose(rst_n) |-> ie_r == 8'h00 && ip_r == 8'h00 && !irq_req)
    else $error("registers not cleared by reset");

endmodule // eight_source_interrupt_ctrl

`default_nettype wire

// *** tb/core_model.sv ***
// Core side of the offer port: takes offers after a short delay, serves,
// then returns. Assumes the controller's clock; one service at a time.
`timescale 1ns/10ps
`default_nettype none

module core_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [1:0] ack_dly,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  output logic irq_ack,
  output logic irq_return,
  output logic taken_stb,
  output logic [7:0] taken_vec
);
  logic busy;
  int wait_c;
  int serve_c;

  // ==========================================
  // Offer handling
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      taken_stb <= 1'b0;
      taken_vec <= 8'h00;
      busy <= 1'b0;
      wait_c <= 0;
      serve_c <= 0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      taken_stb <= 1'b0;
      if (irq_ack && irq_req)
      begin
        taken_stb <= 1'b1;
        taken_vec <= irq_vector;
        busy <= 1'b1;
        serve_c <= 4;
      end
      else if (busy)
      begin
        // Nesting not modelled, so a preempting offer simply waits
        if (serve_c == 0)
        begin
          busy <= 1'b0;
          irq_return <= 1'b1;
        end
        else
          serve_c <= serve_c - 1;
      end
      else if (irq_req && !hold && !irq_ack && !irq_return)
      begin
        if (wait_c >= int'(ack_dly))
        begin
          irq_ack <= 1'b1;
          wait_c <= 0;
        end
        else
          wait_c <= wait_c + 1;
      end
    end
  end
endmodule // core_model

`default_nettype wire

// *** tb/eight_source_interrupt_ctrl_test.sv ***
// Self-checking bench for the eight-source interrupt controller.
// Assumes core_model on the offer port; pins and timers driven here.
`timescale 1ns/10ps
`default_nettype none

module eight_source_interrupt_ctrl_test;
  logic clk, nrst, sfr_wr, sfr_rd, bit_wr, bit_val, hold;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, irq_vector, taken_vec;
  logic ext_irq0_n, ext_irq1_n, ext_irq2_n, ext_irq3_n;
  logic timer0_ovf, timer1_ovf, timer2_irq, serial_irq;
  logic irq_req, irq_ack, irq_return, core_clk_en, osc_en, taken_stb;
  logic [1:0] ack_dly;
  logic [31:0] seed;
  logic [7:0] got[$];
  int exp_q[$];
  int n_fail;
  int num_checks;
  int k;

  eight_source_interrupt_ctrl dut_u (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_val(bit_val), .ext_irq0_n(ext_irq0_n),
    .ext_irq1_n(ext_irq1_n), .ext_irq2_n(ext_irq2_n), .ext_irq3_n(ext_irq3_n),
    .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf), .timer2_irq(timer2_irq),
    .serial_irq(serial_irq), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack(irq_ack), .irq_return(irq_return), .core_clk_en(core_clk_en), .osc_en(osc_en));

  core_model core_u (.clk(clk), .rst_n(nrst), .hold(hold), .ack_dly(ack_dly),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .irq_return(irq_return), .taken_stb(taken_stb), .taken_vec(taken_vec));

  // ==========================================
  // Clock, random ack delay, vector capture
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  always @(posedge clk)
  begin
    seed <= xs(seed);
    ack_dly <= seed[1:0];
    if (taken_stb)
      got.push_back(taken_vec);
    // Level sources are cleared by their owner once served
    if (taken_stb && taken_vec == 8'h23)
      serial_irq <= 1'b0;
    if (taken_stb && taken_vec == 8'h2B)
      timer2_irq <= 1'b0;
    // Level-mode pins are let go once their service starts
    if (taken_stb && taken_vec == 8'h03)
      ext_irq0_n <= 1'b1;
    if (taken_stb && taken_vec == 8'h13)
      ext_irq1_n <= 1'b1;
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_addr <= a;
    bit_val <= v;
    bit_wr <= 1'b1;
    @(posedge clk);
    bit_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    chk(sfr_rdata === e, "register read");
  endtask

  task automatic fire(input logic [7:0] m);
    @(posedge clk);
    ext_irq0_n <= !m[0];
    timer0_ovf <= m[1];
    ext_irq1_n <= !m[2];
    timer1_ovf <= m[3];
    serial_irq <= m[4] | serial_irq;
    timer2_irq <= m[5] | timer2_irq;
    ext_irq2_n <= !m[6];
    ext_irq3_n <= !m[7];
    @(posedge clk);
    timer0_ovf <= 1'b0;
    timer1_ovf <= 1'b0;
    repeat (3) @(posedge clk);
    ext_irq0_n <= 1'b1;
    ext_irq1_n <= 1'b1;
    ext_irq2_n <= 1'b1;
    ext_irq3_n <= 1'b1;
  endtask

  task automatic drain(input int n);
    k = 0;
    while (got.size() < n && k < 500)
    begin
      @(posedge clk);
      k++;
    end
    chk(got.size() == n, "vector count");
    foreach (exp_q[i])
      if (i < got.size())
        chk(got[i] === 8'(3 + 8 * exp_q[i]), "vector order");
    repeat (8) @(posedge clk);
    got.delete();
    exp_q.delete();
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'hC0, 8'h00);
    rd(8'hA8, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h55, 8'h00);
    chk(core_clk_en === 1'b1 && osc_en === 1'b1, "clock enables after reset");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #(5 * 30000);
    n_fail++;
    give_verdict();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    {sfr_wr, sfr_rd, bit_wr, bit_val, hold, timer0_ovf, timer1_ovf} = 7'h00;
    {timer2_irq, serial_irq, sfr_addr, sfr_wdata, bit_addr} = 26'h0;
    {ext_irq0_n, ext_irq1_n, ext_irq2_n, ext_irq3_n} = 4'hF;
    seed = 32'h61A87D85;
    ack_dly = 2'h0;
    nrst = 1'b0;
    n_fail = 0;
    num_checks = 0;
    do_reset();
    // all eight at one level
    // Enables go on after every flag stands, so all eight compete at once
    wr(8'h88, 8'h05);
    wr(8'hC0, 8'h11);
    hold <= 1'b1;
    fire(8'hFF);
    repeat (6) @(posedge clk);
    wr(8'hA8, 8'h3F);
    bw(8'hC2, 1'b1);
    bw(8'hC6, 1'b1);
    hold <= 1'b0;
    for (int i = 0; i < 8; i++)
      exp_q.push_back(i);
    drain(8);
    wr(8'hC0, 8'hD5);
    hold <= 1'b1;
    fire(8'hC0);
    repeat (6) @(posedge clk);
    hold <= 1'b0;
    exp_q.push_back(7);
    exp_q.push_back(6);
    drain(2);
    wr(8'h88, 8'h00);
    wr(8'hB8, 8'h04);
    rd(8'hB8, 8'h04);
    hold <= 1'b1;
    ext_irq0_n <= 1'b0;
    ext_irq1_n <= 1'b0;
    repeat (6) @(posedge clk);
    hold <= 1'b0;
    exp_q.push_back(2);
    exp_q.push_back(0);
    drain(2);
    wr(8'hC0, 8'h11);
    fire(8'h40);
    repeat (6) @(posedge clk);
    chk(got.size() == 0, "disabled source served");
    rd(8'hC0, 8'h13);
    bw(8'hC2, 1'b1);
    exp_q.push_back(6);
    drain(1);
    rd(8'hC0, 8'h15);
    wr(8'hC0, 8'h00);
    @(posedge clk);
    ext_irq3_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'hC0, 8'h20);
    ext_irq3_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'hC0, 8'h00);
    wr(8'hC0, 8'h20);
    rd(8'hC0, 8'h00);
    wr(8'hC0, 8'h05);
    wr(8'h87, 8'h01);
    repeat (2) @(posedge clk);
    chk(core_clk_en === 1'b0, "idle entry");
    fire(8'h40);
    k = 0;
    while (core_clk_en !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk(core_clk_en === 1'b1, "idle wake");
    exp_q.push_back(6);
    drain(1);
    wr(8'h87, 8'h02);
    repeat (2) @(posedge clk);
    chk(osc_en === 1'b0, "power-down entry");
    fire(8'h40);
    repeat (15) @(posedge clk);
    chk(osc_en === 1'b0, "power-down held");
    got.delete();
    do_reset();
    give_verdict();
  end
endmodule // eight_source_interrupt_ctrl_test

`default_nettype wire
